// *** verilog/psc_regs.svh ***
`ifndef PSC_REGS_SVH
`define PSC_REGS_SVH

// Word address width of the storage array.
`define PSC_ADDR_W 18
// Data width, byte lane count and parity width.
`define PSC_DATA_W 32
`define PSC_LANES 4
// Width of the burst counter.
`define PSC_CNT_W 2
// Reset value of the burst counter.
`define PSC_CNT_RST 2'h0
// Burst counter step.
`define PSC_CNT_STEP 2'h1
// Burst order assumed until the strap is caught: interleaved.
`define PSC_ORDER_RST 1'b1

`endif

// *** verilog/psc_pkg.sv ***
package psc_pkg;

  // Kind of the access that is in progress.
  typedef enum logic [1:0] {
    PSC_IDLE,
    PSC_READ,
    PSC_WRITE
  } psc_acc_type;

endpackage

// *** verilog/psc_port_control.sv ***
`timescale 1ns/10ps
`include "psc_regs.svh"
module psc_port_control
  import psc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clockQualifierN,
  input wire logic [`PSC_ADDR_W-1:0] addrIn,
  input wire logic weN,
  input wire logic byteLaneAWriteN,
  input wire logic byteLaneBWriteN,
  input wire logic byteLaneCWriteN,
  input wire logic byteLaneDWriteN,
  input wire logic advanceOrLoad,
  input wire logic selectOneN,
  input wire logic selectTwo,
  input wire logic selectThreeN,
  input wire logic outputEnableN,
  input wire logic burstOrderMode,
  input wire logic [`PSC_DATA_W-1:0] dataIn,
  input wire logic [`PSC_LANES-1:0] parityIn,
  output logic [`PSC_DATA_W-1:0] dataOut,
  output logic [`PSC_LANES-1:0] parityOut,
  output logic dataDriveN
);

  localparam int AW = `PSC_ADDR_W;
  localparam int DW = `PSC_DATA_W;
  localparam int NL = `PSC_LANES;
  localparam int WW = DW + NL;

  logic [WW-1:0] mem [0:(1<<AW)-1];
  logic qualEdge, chipSelected;
  logic [NL-1:0] laneSel;
  psc_acc_type accState_ff, nxt_accState;
  logic [AW-1:0] base_ff, nxt_base, nxt_addr;
  logic [`PSC_CNT_W-1:0] burstCnt_ff, nxt_burstCnt, lowBits;
  logic interleave_ff, strapTaken_ff;
  logic s1Valid_ff, s1Write_ff;
  logic [AW-1:0] s1Addr_ff;
  logic [NL-1:0] s1Lanes_ff;
  logic s2Valid_ff, s2Write_ff;
  logic [AW-1:0] s2Addr_ff;
  logic [NL-1:0] s2Lanes_ff;
  logic readPhase_ff;
  logic [WW-1:0] wrWord, rdWord;
  logic [DW-1:0] dataOut_ff;
  logic [NL-1:0] parityOut_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Input qualification.

  // Only edges with the qualifier low do anything, apart from catching the burst order strap.
  assign qualEdge = !clockQualifierN;
  // All three selects must be active at once to start an access.
  assign chipSelected = !selectOneN && selectTwo && !selectThreeN;
  // Lane selects only count for a write.
  assign laneSel = weN ? '0 : ~{byteLaneDWriteN, byteLaneCWriteN,
                                byteLaneBWriteN, byteLaneAWriteN};

  ////////////////////////////////////////////////////////////////////////////
  // Burst order strap.

  // The strap is caught once, at the first edge after reset release.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      interleave_ff <= `PSC_ORDER_RST;
      strapTaken_ff <= 1'b0;
    end
    else if (!strapTaken_ff)
    begin
      interleave_ff <= burstOrderMode;
      strapTaken_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Load or advance decision.

  // Works out the next access state, base address and burst count.
  always_comb
  begin
    nxt_accState = accState_ff;
    nxt_base = base_ff;
    nxt_burstCnt = burstCnt_ff;
    if (!advanceOrLoad)
    begin
      if (chipSelected)
      begin
        nxt_accState = weN ? PSC_READ : PSC_WRITE;
        nxt_base = addrIn;
        nxt_burstCnt = `PSC_CNT_RST;
      end
      else
      begin
        nxt_accState = PSC_IDLE;
      end
    end
    else if (accState_ff != PSC_IDLE)
    begin
      nxt_burstCnt = burstCnt_ff + `PSC_CNT_STEP;
    end
  end

  // Interleaved order flips the low bits, linear order adds to them.
  assign lowBits = interleave_ff ? (nxt_base[1:0] ^ nxt_burstCnt)
                                 : (nxt_base[1:0] + nxt_burstCnt);
  assign nxt_addr = {nxt_base[AW-1:2], lowBits};

  // Access state and burst counter, frozen on unqualified edges.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      accState_ff <= PSC_IDLE;
      base_ff <= '0;
      burstCnt_ff <= `PSC_CNT_RST;
    end
    else if (qualEdge)
    begin
      accState_ff <= nxt_accState;
      base_ff <= nxt_base;
      burstCnt_ff <= nxt_burstCnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address and control pipeline.

  // Stage one holds the access just taken, stage two the one before it.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1Valid_ff <= 1'b0;
      s1Write_ff <= 1'b0;
      s1Addr_ff <= '0;
      s1Lanes_ff <= '0;
      s2Valid_ff <= 1'b0;
      s2Write_ff <= 1'b0;
      s2Addr_ff <= '0;
      s2Lanes_ff <= '0;
    end
    else if (qualEdge)
    begin
      s1Valid_ff <= nxt_accState != PSC_IDLE;
      s1Write_ff <= nxt_accState == PSC_WRITE;
      s1Addr_ff <= nxt_addr;
      s1Lanes_ff <= (nxt_accState == PSC_WRITE) ? laneSel : '0;
      s2Valid_ff <= s1Valid_ff;
      s2Write_ff <= s1Write_ff;
      s2Addr_ff <= s1Addr_ff;
      s2Lanes_ff <= s1Lanes_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage array and read data.

  // Merges the incoming bytes of a write into the stored word.
  always_comb
  begin
    wrWord = mem[s2Addr_ff];
    for (int i = 0; i < NL; i++)
    begin
      if (s2Lanes_ff[i])
      begin
        wrWord[i*8 +: 8] = dataIn[i*8 +: 8];
        wrWord[DW+i] = parityIn[i];
      end
    end
  end

  // A read right behind a write to the same word sees the new bytes.
  assign rdWord = (s2Valid_ff && s2Write_ff && s2Addr_ff == s1Addr_ff)
                  ? wrWord : mem[s1Addr_ff];

  // Write data is taken two qualified edges after its address.
  always_ff @(posedge core_clk)
  begin
    if (qualEdge && s2Valid_ff && s2Write_ff)
    begin
      mem[s2Addr_ff] <= wrWord;
    end
  end

  // Read data leaves the output register one qualified edge after the address.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dataOut_ff <= '0;
      parityOut_ff <= '0;
      readPhase_ff <= 1'b0;
    end
    else if (qualEdge)
    begin
      readPhase_ff <= s1Valid_ff && !s1Write_ff;
      if (s1Valid_ff && !s1Write_ff)
      begin
        dataOut_ff <= rdWord[DW-1:0];
        parityOut_ff <= rdWord[WW-1:DW];
      end
    end
  end

  assign dataOut = dataOut_ff;
  assign parityOut = parityOut_ff;
  // Drive only in a read data phase with the output enable low.
  assign dataDriveN = !(readPhase_ff && !outputEnableN);

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_loadSel;
    qualEdge && !advanceOrLoad && chipSelected;
  endsequence
  sequence s_writeLoad;
    s_loadSel and (!weN);
  endsequence
  property p_freeze;
    clockQualifierN |=> $stable(s1Valid_ff) && $stable(burstCnt_ff)
      && $stable(s1Addr_ff) && $stable(accState_ff);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("State moved on an unqualified edge.");
  property p_load;
    s_loadSel |=> s1Valid_ff && burstCnt_ff == `PSC_CNT_RST
      && s1Addr_ff == $past(addrIn);
  endproperty
  a_load: assert property (p_load)
    else $error("Presented address was not loaded.");
  property p_deselect;
    qualEdge && !advanceOrLoad && !chipSelected |=> !s1Valid_ff;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("Access started without all selects active.");
  property p_advance;
    qualEdge && advanceOrLoad && accState_ff != PSC_IDLE
      |=> burstCnt_ff == $past(burstCnt_ff) + `PSC_CNT_STEP;
  endproperty
  a_advance: assert property (p_advance)
    else $error("Burst counter did not step on advance.");
  property p_weSample;
    s_loadSel |=> s1Write_ff == !$past(weN);
  endproperty
  a_weSample: assert property (p_weSample)
    else $error("Write enable sampled wrongly.");
  property p_lanes;
    qualEdge && !weN && ((!advanceOrLoad && chipSelected)
      || (advanceOrLoad && accState_ff == PSC_WRITE))
      |=> s1Lanes_ff == ~$past({byteLaneDWriteN, byteLaneCWriteN,
                                byteLaneBWriteN, byteLaneAWriteN});
  endproperty
  a_lanes: assert property (p_lanes)
    else $error("Lane selects not taken for the beat.");
  property p_writeFloat;
    s_writeLoad ##1 qualEdge |=> dataDriveN;
  endproperty
  a_writeFloat: assert property (p_writeFloat)
    else $error("Outputs driven in a write data phase.");
  property p_stretch;
    clockQualifierN && !dataDriveN && !outputEnableN |=> !dataDriveN;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("Stretched cycle dropped the read data.");
  property p_strap;
    strapTaken_ff |=> $stable(interleave_ff);
  endproperty
  a_strap: assert property (p_strap)
    else $error("Burst order changed during operation.");

endmodule // psc_port_control

// *** tb/psc_host_model.sv ***
`timescale 1ns/10ps
`include "psc_regs.svh"
module psc_host_model
(
  input wire logic core_clk,
  output logic clockQualifierN,
  output logic [`PSC_ADDR_W-1:0] addrIn,
  output logic weN,
  output logic byteLaneAWriteN,
  output logic byteLaneBWriteN,
  output logic byteLaneCWriteN,
  output logic byteLaneDWriteN,
  output logic advanceOrLoad,
  output logic selectOneN,
  output logic selectTwo,
  output logic selectThreeN,
  output logic [`PSC_DATA_W-1:0] dataIn,
  output logic [`PSC_LANES-1:0] parityIn
);
  // Parks the pins in a deselect cycle.
  initial
  begin
    {clockQualifierN, weN, advanceOrLoad} = 3'h2;
    addrIn = '0;
    {byteLaneDWriteN, byteLaneCWriteN, byteLaneBWriteN} = 3'h7;
    byteLaneAWriteN = 1'b1;
    {selectOneN, selectTwo, selectThreeN} = 3'h6;
    {parityIn, dataIn} = '0;
  end

  // Drives one cycle after a fall and holds it over the next rise.
  task automatic cyc(input logic q, input logic [17:0] a, input logic w,
    input logic [3:0] ln, input logic adv, input logic [2:0] s,
    input logic dv, input logic [35:0] d);
    @(negedge core_clk);
    clockQualifierN = q;
    addrIn = a;
    weN = w;
    {byteLaneDWriteN, byteLaneCWriteN} = ln[3:2];
    {byteLaneBWriteN, byteLaneAWriteN} = ln[1:0];
    advanceOrLoad = adv;
    {selectOneN, selectTwo, selectThreeN} = s;
    // Outside a data phase the lines show the inverse, never stale data.
    {parityIn, dataIn} = dv ? d : ~{parityIn, dataIn};
    @(posedge core_clk);
  endtask
endmodule // psc_host_model

// *** tb/tb_pipelined_sram_port_control.sv ***
`timescale 1ns/10ps
`include "psc_regs.svh"
module tb_pipelined_sram_port_control;
  localparam logic [2:0] ACT = 3'h2;
  localparam logic [2:0] DES = 3'h6;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic outputEnableN = 1'b0;
  logic burstOrderMode = 1'b1;
  logic qN, weN, lA, lB, lC, lD, adv, s1N, s2, s3N, dataDriveN;
  logic [17:0] addrIn;
  logic [31:0] dataIn, dataOut;
  logic [3:0] parityIn, parityOut;
  int failures = 0;
  int checksDone = 0;

  // Clock and the two parties.
  always #25 core_clk = ~core_clk;
  psc_host_model psc_host_model_i (.core_clk(core_clk),
    .clockQualifierN(qN), .addrIn(addrIn), .weN(weN),
    .byteLaneAWriteN(lA), .byteLaneBWriteN(lB), .byteLaneCWriteN(lC),
    .byteLaneDWriteN(lD), .advanceOrLoad(adv), .selectOneN(s1N),
    .selectTwo(s2), .selectThreeN(s3N), .dataIn(dataIn),
    .parityIn(parityIn));
  psc_port_control psc_port_control_i (.core_clk(core_clk), .rstn(rstn),
    .clockQualifierN(qN), .addrIn(addrIn), .weN(weN),
    .byteLaneAWriteN(lA), .byteLaneBWriteN(lB), .byteLaneCWriteN(lC),
    .byteLaneDWriteN(lD), .advanceOrLoad(adv), .selectOneN(s1N),
    .selectTwo(s2), .selectThreeN(s3N), .outputEnableN(outputEnableN),
    .burstOrderMode(burstOrderMode), .dataIn(dataIn),
    .parityIn(parityIn), .dataOut(dataOut), .parityOut(parityOut),
    .dataDriveN(dataDriveN));

  ////////////////////////////////////////////////////////////////////////
  // Helpers.
  task automatic check(input string n, input logic [35:0] seen, exp);
    checksDone++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", n, exp, seen);
    end
  endtask

  // A word whose pattern follows from its address.
  function automatic logic [35:0] pat(input logic [17:0] a);
    pat = {a[3:0], a[15:0], ~a[15:0]};
  endfunction

  // Old word with the selected lanes taken from the new one.
  function automatic logic [35:0] mrg(input logic [35:0] o, n,
    input logic [3:0] ln);
    mrg = o;
    for (int i = 0; i < 4; i++)
      if (!ln[i])
        {mrg[32+i], mrg[8*i+:8]} = {n[32+i], n[8*i+:8]};
  endfunction

  task automatic rst(input logic mode);
    @(negedge core_clk);
    rstn = 1'b0;
    burstOrderMode = mode;
    repeat (20) @(negedge core_clk);
    check("reset drive", dataDriveN, 1'b1);
    check("reset data", {parityOut, dataOut}, '0);
    rstn = 1'b1;
  endtask

  // Write: address edge, one quiet edge, then the data edge.
  task automatic wr(input logic [17:0] a, input logic [3:0] ln,
    input logic [35:0] d);
    psc_host_model_i.cyc(1'b0, a, 1'b0, ln, 1'b0, ACT, 1'b0, '0);
    psc_host_model_i.cyc(1'b0, a, 1'b1, 4'hf, 1'b0, DES, 1'b0, '0);
    psc_host_model_i.cyc(1'b0, a, 1'b1, 4'hf, 1'b0, DES, 1'b1, d);
  endtask

  // Read with lanes low, which must not write anything.
  task automatic rd(input logic [17:0] a, input logic [35:0] e,
    input logic drv);
    psc_host_model_i.cyc(1'b0, a, 1'b1, 4'h0, 1'b0, ACT, 1'b0, '0);
    psc_host_model_i.cyc(1'b0, a, 1'b1, 4'hf, 1'b0, DES, 1'b0, '0);
    #5;
    check("read data", {parityOut, dataOut}, e);
    check("read drive", dataDriveN, !drv);
    psc_host_model_i.cyc(1'b0, a, 1'b1, 4'hf, 1'b0, DES, 1'b0, '0);
    #5;
    check("drive end", dataDriveN, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_lanes();
    logic [17:0] a = 18'h0_0155;
    wr(a, 4'h0, pat(a));
    wr(a, 4'hd, ~pat(a));
    rd(a, mrg(pat(a), ~pat(a), 4'hd), 1'b1);
    rd(a, mrg(pat(a), ~pat(a), 4'hd), 1'b1);
    $display("done: lanes");
  endtask

  task automatic t_stretch();
    wr(18'h0_0200, 4'h0, pat(18'h0_0200));
    wr(18'h0_0300, 4'h0, pat(18'h0_0300));
    psc_host_model_i.cyc(1'b0, 18'h0_0200, 1'b1, 4'hf, 1'b0, ACT, 1'b0, '0);
    psc_host_model_i.cyc(1'b0, 18'h0_0300, 1'b1, 4'hf, 1'b0, DES, 1'b0, '0);
    // The read data phase is stretched while a write is offered unqualified.
    repeat (3)
    begin
      psc_host_model_i.cyc(1'b1, 18'h0_0300, 1'b0, 4'h0, 1'b0, ACT, 1'b1,
        '0);
      #5;
      check("frozen drive", dataDriveN, 1'b0);
      check("stretched read", {parityOut, dataOut}, pat(18'h0_0200));
    end
    psc_host_model_i.cyc(1'b0, 18'h0_0300, 1'b1, 4'hf, 1'b0, DES, 1'b0, '0);
    #5;
    check("stretch end", dataDriveN, 1'b1);
    rd(18'h0_0300, pat(18'h0_0300), 1'b1);
    $display("done: stretch");
  endtask

  task automatic t_desel();
    logic [2:0] s [3] = '{3'h6, 3'h0, 3'h3};
    for (int i = 0; i < 3; i++)
    begin
      psc_host_model_i.cyc(1'b0, 18'h0_0200, 1'b1, 4'hf, 1'b0, s[i], 1'b0,
        '0);
      psc_host_model_i.cyc(1'b0, 18'h0_0200, 1'b1, 4'hf, 1'b0, DES, 1'b0,
        '0);
      #5;
      check("deselected drive", dataDriveN, 1'b1);
    end
    @(negedge core_clk);
    outputEnableN = 1'b1;
    rd(18'h0_0200, pat(18'h0_0200), 1'b0);
    @(negedge core_clk);
    outputEnableN = 1'b0;
    $display("done: deselect");
  endtask

  task automatic t_burst(input logic mode);
    logic [17:0] b = 18'h0_0124;
    logic [1:0] k;
    rst(mode);
    // One write burst: each beat's data follows its address by two edges.
    psc_host_model_i.cyc(1'b0, b, 1'b0, 4'h0, 1'b0, ACT, 1'b0, '0);
    for (int i = 0; i < 5; i++)
    begin
      k = i[1:0] - 2'h1;
      psc_host_model_i.cyc(1'b0, b, 1'b0, 4'h0, i < 3, i < 3 ? ACT : DES,
        i > 0, pat({b[17:2], k}) ^ {36{~mode}});
    end
    psc_host_model_i.cyc(1'b0, b + 18'h1, 1'b1, 4'h0, 1'b0, ACT, 1'b0, '0);
    for (int i = 0; i < 4; i++)
    begin
      k = mode ? 2'h1 ^ i[1:0] : 2'h1 + i[1:0];
      psc_host_model_i.cyc(1'b0, b, 1'b1, 4'h0, i < 3, i < 3 ? ACT : DES,
        1'b0, '0);
      #5;
      check("burst", {parityOut, dataOut},
        pat({b[17:2], k}) ^ {36{~mode}});
    end
    $display("done: burst");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Verdict, main sequence and watchdog.
  task automatic wrap_up();
    $display("checks %0d, failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    rst(1'b1);
    t_lanes();
    t_stretch();
    t_desel();
    t_burst(1'b1);
    t_burst(1'b0);
    wrap_up();
  end

  initial
  begin
    repeat (3000) @(posedge core_clk);
    failures++;
    wrap_up();
  end
endmodule // tb_pipelined_sram_port_control
